// file: hw/spced_defs.vh
// Register offsets, field positions, reset values for the serial pin control block.
// Assumes inclusion by the design files of this block only.
`ifndef SPCED_DEFS_VH
`define SPCED_DEFS_VH

`define SPCED_OFF_IO_CONTROL 12'h000
`define SPCED_OFF_ARM 12'h004
`define SPCED_OFF_PIN_STATUS 12'h008
`define SPCED_OFF_CHAN_CMD 12'h00c
`define SPCED_OFF_DAISY 12'h010

`define SPCED_IOC_OUT_FN_LO 6
`define SPCED_CCA_ROUTE_LO 8
`define SPCED_DCC_PENDING 1
`define SPCED_DCC_PIN_IE 0
`define SPCED_DCC_MASTER_IE 2

`define SPCED_IOC_RESET 16'h0000
`define SPCED_ARM_RESET 16'h0000
`define SPCED_CCA_RESET 2'h0

`define SPCED_FN_DRIVE 2'h0
`define SPCED_FN_FLOAT 2'h1
`define SPCED_FN_LOW 2'h2
`define SPCED_FN_HIGH 2'h3

`define SPCED_RT_NORMAL 2'h0
`define SPCED_RT_ECHO 2'h1
`define SPCED_RT_PIN_LOOP 2'h2
`define SPCED_RT_INT_LOOP 2'h3

`endif

// file: hw/spced_edge_cell.v
// One monitored source: edge arm, detection latch, latched flag and frozen level.
// Assumes the level input is already synchronous to pclk.
`timescale 1ns/10ps
module spced_edge_cell (
   input wire pclk,
   input wire presetn,
   input wire soft_reset,
   input wire level,
   input wire arm_fall,
   input wire arm_rise,
   input wire flag_clear,
   output reg flag,
   output reg level_seen,
   output wire set_pulse
);
   reg prev;
   reg detect;
   wire edge_hit;

   // Previous sample for edge compare
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b0;
      end else begin
         prev <= level;
      end
   end

   assign edge_hit = (arm_rise & level & ~prev) | (arm_fall & ~level & prev);
   assign set_pulse = ~flag & detect;

   // Detection latch hidden from software; new edge wins over the hand-off clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         detect <= 1'b0;
      end else if (soft_reset) begin
         detect <= 1'b0;
      end else if (edge_hit) begin
         detect <= 1'b1;
      end else if (set_pulse) begin
         detect <= 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag <= 1'b0;
         level_seen <= 1'b0;
      end else if (soft_reset) begin
         flag <= 1'b0;
         level_seen <= ~level;
      end else if (set_pulse) begin
         flag <= 1'b1;
      end else if (flag && flag_clear) begin
         flag <= 1'b0;
         level_seen <= ~level;
      end else if (!flag) begin
         level_seen <= ~level;
      end
   end
endmodule

// file: hw/spced_top.v
// Serial pin control: output pin function, tx/rx routing, edge detection status.
// Assumes an APB master on pclk; pins are asynchronous and synchronised here.
//
// Notes on behaviour
// - Output function 00 drives tx data, 01 floats, 10 low, 11 high.
// - Output function resets to 00 so the pin is driven after reset.
// - Routing 00 keeps transmitter and receiver independent on their own pins.
// - Routing 01 copies input pin to output pin under output function 00, transmitter data dropped.
// - Routing 10 feeds receiver from output pin; floating lets outside drive it.
// - Routing 11 feeds transmitter data to receiver regardless of output function.
// - Each pin has rising and falling arm bits; 1 detects, 0 ignores.
// - Arm layout per pin falling then rising, bits 15-4; bits 3-0 other sources.
// - Edge detection works whether pins are inputs or outputs.
// - An armed edge sets a hidden per-pin detection latch.
// - Hardware or software reset clears all latched flags.
// - With flag clear, level bit tracks pin, 1 meaning low.
// - Flag clear and latch set: set flag, clear latch, set pending bit.
// - With flag set, level and flag stay frozen until software writes 1.
// - Writing 1 clears flag; edges seen meanwhile set it again at once.
// - Writing 0 to flags does nothing; level bit writes are ignored.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "spced_defs.vh"
module spced_top #(
   parameter NPIN = 6,
   parameter NAUX = 4
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire soft_reset,
   input wire rx_data_pin,
   input wire tx_pin_in,
   output reg tx_pin_out,
   output reg tx_pin_oe,
   input wire tx_serial_data,
   output reg rx_serial_data,
   input wire receive_clock_pin,
   input wire transmit_clock_pin,
   input wire receive_request_pin,
   input wire transmit_request_pin,
   input wire carrier_detect_pin,
   input wire clear_to_send_pin,
   input wire [NAUX-1:0] aux_level,
   output reg irq
);
   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg [15:0] io_control;
   reg [15:0] status_interrupt_arm;
   reg [1:0] tx_rx_routing;
   reg pin_interrupt_pending;
   reg pin_irq_enable;
   reg master_irq_enable;

   wire [1:0] output_pin_function;
   wire access;
   wire wr;
   wire [NPIN+NAUX-1:0] flag;
   wire [NPIN+NAUX-1:0] level_seen;
   wire [NPIN+NAUX-1:0] set_pulse;
   wire [NPIN+NAUX-1:0] arm_fall;
   wire [NPIN+NAUX-1:0] arm_rise;
   wire [NPIN+NAUX-1:0] flag_clear;
   wire [NPIN+NAUX-1:0] cell_level;
   wire [15:0] status_word;

   assign output_pin_function = io_control[`SPCED_IOC_OUT_FN_LO+1:`SPCED_IOC_OUT_FN_LO];
   assign access = psel & penable;
   assign wr = access & pwrite;

   ////////////////////////////////////////////////////////////////////////
   // Address selects and strobes shared by the flag and interrupt paths
   wire sel_pin_status;
   wire sel_daisy;
   wire daisy_write;
   wire pin_pending_set;
   wire irq_request;

   assign sel_pin_status = (paddr == `SPCED_OFF_PIN_STATUS);
   assign sel_daisy = (paddr == `SPCED_OFF_DAISY);
   assign daisy_write = wr & sel_daisy;
   // Only the six pins feed the shared pending bit; aux flags stay local
   assign pin_pending_set = |set_pulse[NPIN+NAUX-1:NAUX];
   // Pending stays readable to software whatever the enables say
   assign irq_request = pin_interrupt_pending & pin_irq_enable & master_irq_enable;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, pin order receive clock down to clear-to-send
   reg [NPIN-1:0] pin_meta;
   reg [NPIN-1:0] pin_sync;
   reg [1:0] rx_meta;
   reg [1:0] rx_sync;
   wire [NPIN-1:0] pin_raw;

   // Pins sampled in any direction; no gate on the configured function
   assign pin_raw = {receive_clock_pin,
                     transmit_clock_pin,
                     receive_request_pin,
                     transmit_request_pin,
                     carrier_detect_pin,
                     clear_to_send_pin};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Idle high, so arming after reset meets no false edge
         pin_meta <= {NPIN{1'b1}};
         pin_sync <= {NPIN{1'b1}};
         rx_meta <= 2'h3;
         rx_sync <= 2'h3;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         rx_meta <= {tx_pin_in, rx_data_pin};
         rx_sync <= rx_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pin and routing
   reg next_tx_out;
   reg next_tx_oe;
   reg next_rx_data;
   reg echo_src;

   // Echo adds the two sync stages to the pin-to-pin delay
   always @* begin
      echo_src = (tx_rx_routing == `SPCED_RT_ECHO) ? rx_sync[0] : tx_serial_data;
      next_tx_out = 1'b1;
      next_tx_oe = 1'b1;
      case (output_pin_function)
         `SPCED_FN_DRIVE: next_tx_out = echo_src;
         // Float keeps the data high so a later drive starts from idle
         `SPCED_FN_FLOAT: next_tx_oe = 1'b0;
         `SPCED_FN_LOW: next_tx_out = 1'b0;
         `SPCED_FN_HIGH: next_tx_out = 1'b1;
         default: next_tx_oe = 1'b0;
      endcase
      case (tx_rx_routing)
         `SPCED_RT_NORMAL: next_rx_data = rx_sync[0];
         `SPCED_RT_ECHO: next_rx_data = rx_sync[0];
         // Pin level seen back through the pad, floating lets a remote drive it
         `SPCED_RT_PIN_LOOP: next_rx_data = rx_sync[1];
         // Internal loop bypasses the pad, so the output function has no say
         `SPCED_RT_INT_LOOP: next_rx_data = tx_serial_data;
         default: next_rx_data = rx_sync[0];
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pin_out <= 1'b1;
         tx_pin_oe <= 1'b1;
         rx_serial_data <= 1'b1;
      end else begin
         tx_pin_out <= next_tx_out;
         tx_pin_oe <= next_tx_oe;
         rx_serial_data <= next_rx_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge cells; six pins then four internal sources
   // Aux levels come from this clock, so they skip the synchronisers
   assign cell_level = {pin_sync, aux_level};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN + NAUX; gi = gi + 1) begin : g_cell
         if (gi >= NAUX) begin : g_pin
            assign arm_fall[gi] = status_interrupt_arm[2*gi-NAUX+1];
            assign arm_rise[gi] = status_interrupt_arm[2*gi-NAUX];
            assign flag_clear[gi] = wr && sel_pin_status &&
                                    pwdata[2*gi-NAUX+1];
            assign status_word[2*gi-NAUX+1] = flag[gi];
            assign status_word[2*gi-NAUX] = level_seen[gi];
         end else begin : g_aux
            // Internal sources are pulses; rising edge arms them
            assign arm_fall[gi] = 1'b0;
            assign arm_rise[gi] = status_interrupt_arm[gi];
            assign flag_clear[gi] = wr && sel_pin_status &&
                                    pwdata[gi];
            assign status_word[gi] = flag[gi];
         end
         spced_edge_cell u_cell (
            .pclk(pclk),
            .presetn(presetn),
            .soft_reset(soft_reset),
            .level(cell_level[gi]),
            .arm_fall(arm_fall[gi]),
            .arm_rise(arm_rise[gi]),
            .flag_clear(flag_clear[gi]),
            .flag(flag[gi]),
            .level_seen(level_seen[gi]),
            .set_pulse(set_pulse[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // APB register writes
   // Software reset outranks a write landing in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_control <= `SPCED_IOC_RESET;
         status_interrupt_arm <= `SPCED_ARM_RESET;
         tx_rx_routing <= `SPCED_CCA_RESET;
         pin_irq_enable <= 1'b0;
         master_irq_enable <= 1'b0;
      end else if (soft_reset) begin
         io_control <= `SPCED_IOC_RESET;
         status_interrupt_arm <= `SPCED_ARM_RESET;
         tx_rx_routing <= `SPCED_CCA_RESET;
         pin_irq_enable <= 1'b0;
         master_irq_enable <= 1'b0;
      end else if (wr) begin
         case (paddr)
            `SPCED_OFF_IO_CONTROL: io_control <= pwdata[15:0];
            `SPCED_OFF_ARM: status_interrupt_arm <= pwdata[15:0];
            `SPCED_OFF_CHAN_CMD:
               tx_rx_routing <= pwdata[`SPCED_CCA_ROUTE_LO+1:`SPCED_CCA_ROUTE_LO];
            `SPCED_OFF_DAISY: begin
               pin_irq_enable <= pwdata[`SPCED_DCC_PIN_IE];
               master_irq_enable <= pwdata[`SPCED_DCC_MASTER_IE];
            end
            // Unmapped writes are dropped; the response flags them with pslverr
            default: io_control <= io_control;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin interrupt pending and request
   // Pending bit: new event wins over a same-cycle software clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_interrupt_pending <= 1'b0;
      end else if (soft_reset) begin
         pin_interrupt_pending <= 1'b0;
      end else if (pin_pending_set) begin
         pin_interrupt_pending <= 1'b1;
      end else if (daisy_write) begin
         pin_interrupt_pending <= pwdata[`SPCED_DCC_PENDING];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_request;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB read and response, one wait-free access phase
   // Reads have no side effects; flags clear only on a written 1
   reg [31:0] next_rdata;
   reg next_err;

   always @* begin
      next_rdata = 32'h00000000;
      next_err = 1'b0;
      case (paddr)
         `SPCED_OFF_IO_CONTROL: next_rdata = {16'h0000, io_control};
         `SPCED_OFF_ARM: next_rdata = {16'h0000, status_interrupt_arm};
         `SPCED_OFF_PIN_STATUS: next_rdata = {16'h0000, status_word};
         `SPCED_OFF_CHAN_CMD: next_rdata = {22'h000000, tx_rx_routing, 8'h00};
         `SPCED_OFF_DAISY: next_rdata = {29'h00000000, master_irq_enable,
                                         pin_interrupt_pending, pin_irq_enable};
         default: next_err = 1'b1;
      endcase
   end

   // Zero wait states: pready answers the setup cycle one edge later
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & next_err;
         if (psel && !penable && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end
endmodule

// file: bench/spced_monitor.sv
// Port-level checker for the serial pin control block.
// Assumes a bind from the bench top; register writes mirrored from APB.
`timescale 1ns/10ps
module spced_monitor (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire soft_reset,
   input wire rx_data_pin,
   input wire tx_serial_data,
   input wire tx_pin_out,
   input wire tx_pin_oe,
   input wire rx_serial_data,
   input wire irq
);
   reg [1:0] fn;
   reg [1:0] route;
   reg [1:0] ena;
   reg [2:0] age;
   wire wr = psel && penable && pready && pwrite;
   // Age gates checks until the sync chain holds post-change samples
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fn <= 2'h0;
         route <= 2'h0;
         ena <= 2'h0;
         age <= 3'h0;
      end else begin
         fn <= soft_reset ? 2'h0 : (wr && paddr == 12'h000) ? pwdata[7:6] : fn;
         route <= soft_reset ? 2'h0 : (wr && paddr == 12'h00c) ? pwdata[9:8] : route;
         ena <= soft_reset ? 2'h0 : (wr && paddr == 12'h010) ? {pwdata[2], pwdata[0]} : ena;
         age <= (soft_reset || wr && (paddr == 12'h000 || paddr == 12'h00c)) ? 3'h0 :
            age + {2'h0, age != 3'h7};
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_FN_LOW: assert property (age > 1 && route != 2'h1 && fn == 2'h2 |->
      tx_pin_oe && !tx_pin_out) else $error("output pin not forced low");
   AST_FN_HIGH: assert property (age > 1 && route != 2'h1 && fn == 2'h3 |->
      tx_pin_oe && tx_pin_out) else $error("output pin not forced high");
   AST_FN_FLOAT: assert property (age > 1 && route != 2'h1 && fn == 2'h1 |->
      !tx_pin_oe) else $error("output pin driven while floating");
   AST_FN_DRIVE: assert property (age > 1 && route != 2'h1 && fn == 2'h0 |->
      tx_pin_oe && tx_pin_out == $past(tx_serial_data)) else $error("tx data not on pin");
   AST_RESET_DRIVE: assert property ($rose(presetn) |-> tx_pin_oe)
      else $error("output pin not driven after reset");
   AST_INT_LOOP: assert property (age > 1 && route == 2'h3 |->
      rx_serial_data == $past(tx_serial_data)) else $error("internal loop broken");
   AST_NORMAL_RX: assert property (age > 3 && route == 2'h0 |->
      rx_serial_data == $past(rx_data_pin, 3)) else $error("receiver not fed from input pin");
   AST_ECHO: assert property (age > 3 && route == 2'h1 |->
      tx_pin_out == $past(rx_data_pin, 3)) else $error("echo path broken");
   AST_IRQ_GATE: assert property (irq |-> $past(ena) == 2'h3)
      else $error("irq without both enables");
   cover property (irq);
   cover property (pslverr);
   cover property (route == 2'h2 && !tx_pin_oe);
endmodule

// file: bench/spced_line_model.sv
// Far side of the serial output wire: a remote sender on a shared line.
// Assumes nobody else drives the wire; no pull, so a released wire shows the inverse.
`timescale 1ns/10ps
module spced_line_model (
   input wire pclk,
   input wire tx_pin_out,
   input wire tx_pin_oe,
   input wire remote_en,
   input wire remote_val,
   output wire tx_pin_in
);
   // Last level the pad drove; a stale copy would hide a missed float
   reg last_drive = 1'b1;
   always @(posedge pclk) begin
      if (tx_pin_oe) begin
         last_drive <= tx_pin_out;
      end
   end
   assign tx_pin_in = tx_pin_oe ? tx_pin_out : (remote_en ? remote_val : ~last_drive);
endmodule

// file: bench/testbench.sv
// Self-checking bench for the serial pin control block.
// Assumes the design files and the line model compiled first.
`timescale 1ns/10ps
module testbench;
   reg pclk, presetn, psel, penable, pwrite, soft_reset;
   reg rx_data_pin, tx_serial_data, remote_en, remote_val, serr;
   reg [11:0] paddr;
   reg [31:0] pwdata, rv;
   reg [5:0] pins;
   reg [3:0] aux;
   reg [10:0] row;
   wire [31:0] prdata;
   wire pready, pslverr, tx_pin_in, tx_pin_out, tx_pin_oe, rx_serial_data, irq;
   integer errors, n_compared, i;
   // Per row: fn, route, txd, rxd, remote en/val, then expected out, oe, rx
   localparam [109:0] rows = {11'h7a6, 11'h3c1, 11'h319, 11'h562, 11'h0a7,
      11'h606, 11'h463, 11'h240, 11'h023, 11'h046};
   spced_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .soft_reset(soft_reset), .rx_data_pin(rx_data_pin),
      .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
      .tx_serial_data(tx_serial_data), .rx_serial_data(rx_serial_data),
      .receive_clock_pin(pins[5]), .transmit_clock_pin(pins[4]),
      .receive_request_pin(pins[3]), .transmit_request_pin(pins[2]),
      .carrier_detect_pin(pins[1]), .clear_to_send_pin(pins[0]), .aux_level(aux), .irq(irq));
   spced_line_model line (.pclk(pclk), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
      .remote_en(remote_en), .remote_val(remote_val), .tx_pin_in(tx_pin_in));
   ////////////////////////////////////////
   task complete_run;
      begin
         $display("compared %0d mismatches %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task check(input string name, input [15:0] seen, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // Entered just after a rising edge; leaves one idle edge behind
   // A slave that never answers is left to the watchdog
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) begin
            @(posedge pclk);
         end
         rv = prdata;
         serr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task settle(input integer n);
      begin
         repeat (n) @(posedge pclk);
      end
   endtask
   ////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      #(25 * 20000);
      errors = errors + 1;
      complete_run;
   end
   initial begin
      {presetn, psel, penable, pwrite, soft_reset, remote_en, remote_val} = 7'h0;
      {rx_data_pin, tx_serial_data, paddr, pwdata, pins, aux} = {2'h3, 44'h0, 6'h3f, 4'h0};
      errors = 0;
      n_compared = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 10; i = i + 1) begin
         row = rows[i * 11 +: 11];
         apb(1'b1, 12'h000, {24'h0, row[10:9], 6'h0});
         apb(1'b1, 12'h00c, {22'h0, row[8:7], 8'h0});
         {tx_serial_data, rx_data_pin, remote_en, remote_val} <= row[6:3];
         settle(6);
         #1;
         if (row[1])
            check("tx_pin_out", {15'h0, tx_pin_out}, {15'h0, row[2]});
         check("tx_pin_oe", {15'h0, tx_pin_oe}, {15'h0, row[1]});
         check("rx_serial_data", {15'h0, rx_serial_data}, {15'h0, row[0]});
         $display("routing row %0d done", i);
         @(posedge pclk);
      end
      presetn <= 1'b0;
      settle(2);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      check("io_control", rv[31:16] | rv[15:0], 16'h0000);
      apb(1'b0, 12'h008, 32'h0);
      check("pin_event_status", rv[15:0], 16'h0000);
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped", {serr, rv[14:0]}, 16'h8000);
      $display("reset test done");
      apb(1'b1, 12'h004, 32'h0098);
      {pins[1], aux[3]} <= 2'h1;
      settle(8);
      pins[1:0] <= 2'h2;
      settle(8);
      apb(1'b0, 12'h008, 32'h0);
      check("pin_event_status", rv[15:0], 16'h00d8);
      apb(1'b0, 12'h010, 32'h0);
      check("daisy_chain_control", rv[15:0], 16'h0002);
      pins[0] <= 1'b1;
      settle(8);
      apb(1'b1, 12'h008, 32'h0050);
      apb(1'b0, 12'h008, 32'h0);
      check("pin_event_status", rv[15:0], 16'h00e8);
      pins[1] <= 1'b0;
      apb(1'b1, 12'h010, 32'h5);
      settle(6);
      check("irq", {15'h0, irq}, 16'h0000);
      apb(1'b1, 12'h008, rv);
      settle(4);
      apb(1'b0, 12'h008, 32'h0);
      check("pin_event_status", rv[15:0], 16'h00c0);
      check("irq", {15'h0, irq}, 16'h0001);
      apb(1'b1, 12'h010, 32'h3);
      settle(4);
      check("irq", {15'h0, irq}, 16'h0000);
      apb(1'b1, 12'h008, 32'h0080);
      apb(1'b0, 12'h008, 32'h0);
      check("pin_event_status", rv[15:0], 16'h0040);
      $display("edge test done");
      aux[3] <= 1'b0;
      settle(4);
      aux[3] <= 1'b1;
      settle(8);
      soft_reset <= 1'b1;
      @(posedge pclk);
      soft_reset <= 1'b0;
      settle(4);
      apb(1'b0, 12'h008, 32'h0);
      check("pin_event_status", rv[15:0], 16'h0040);
      apb(1'b0, 12'h004, 32'h0);
      check("status_interrupt_arm", rv[15:0], 16'h0000);
      $display("soft reset test done");
      complete_run;
   end
endmodule
bind spced_top spced_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .soft_reset(soft_reset), .rx_data_pin(rx_data_pin),
   .tx_serial_data(tx_serial_data), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
   .rx_serial_data(rx_serial_data), .irq(irq));
